// *** inc/txdesc_defines.svh ***
// constants for the transmit descriptor decoder
// assumes inclusion by bare name from the design files
`ifndef TXDESC_DEFINES_SVH
`define TXDESC_DEFINES_SVH
`define LAST_SEG_BIT      30
`define FIRST_SEG_BIT     29
`define CRC_DIS_BIT       26
`define END_RING_BIT      25
`define CHAINED_BIT       24
`define PAD_DIS_BIT       23
`define RSVD_BIT          22
`define BUF2_SIZE_HI      21
`define BUF2_SIZE_LO      11
`define BUF1_SIZE_HI      10
`define BUF1_SIZE_LO      0
`define DESC_WORDS        3'h4
`define WORD_STRIDE       32'h0000_0004
`define MIN_FRAME_BYTES   11'h040
`define FIFO_DEPTH        8
`define FIFO_AW           3
`endif

// *** inc/txdesc_pkg.sv ***
// types shared by the transmit descriptor decoder files
// assumes the defines header is compiled alongside
package txdesc_pkg;
   // decoded descriptor handed to the transfer side
   typedef struct packed {
      logic        first_seg;
      logic        last_seg;
      logic        crc_append;
      logic        pad_enable;
      logic        end_of_ring;
      logic        chained;
      logic [10:0] buf1_size;
      logic [10:0] buf2_size;
      logic [31:0] buf1_ptr;
      logic [31:0] buf2_ptr;
      logic [31:0] next_desc;
   } decoded_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_REQ   = 3'b001,
      ST_WAIT  = 3'b010,
      ST_EMIT  = 3'b011
   } state_t;
endpackage

// *** verilog/tx_fifo.sv ***
// small fifo holding decoded descriptors
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             clk,      // clock
   input  wire logic             rst,      // async reset
   input  wire logic             in_valid, // write request
   output logic                  in_ready, // room free
   input  wire logic [WIDTH-1:0] in_data,  // write data
   output logic                  out_valid,// data present
   input  wire logic             out_ready,// reader takes
   output logic      [WIDTH-1:0] out_data  // read data
);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } fst_t;

   fst_t             s_r;
   fst_t             s_nxt;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             wr;
   logic             rd;

   assign in_ready  = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_r.cnt != '0);
   assign out_data  = mem[s_r.rp];
   assign wr        = in_valid && in_ready;
   assign rd        = out_valid && out_ready;

   always_comb begin
      s_nxt = s_r;
      if (wr) begin
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (rd) begin
         s_nxt.rp = s_r.rp + 1'b1;
      end
      if (wr && !rd) begin
         s_nxt.cnt = s_r.cnt + 1'b1;
      end else if (rd && !wr) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (wr) begin
         mem[s_r.wp] <= in_data;
      end
   end
endmodule
`default_nettype wire

// *** verilog/desc_word_reg.sv ***
// holding register for the last three of the four fetched descriptor words
// assumes words arrive one per strobe, status word first
`timescale 1ns/1ps
`default_nettype none
module desc_word_reg (
   input  wire logic        clk,    // clock
   input  wire logic        rst,    // async reset
   input  wire logic        we,     // word strobe
   input  wire logic [1:0]  idx,    // word index
   input  wire logic [31:0] wdata,  // word value
   output logic      [31:0] ctrl,   // control word
   output logic      [31:0] ptr1,   // buffer one pointer
   output logic      [31:0] ptr2    // second address word
);
   typedef struct packed {
      logic [31:0] c;
      logic [31:0] p1;
      logic [31:0] p2;
   } wst_t;

   wst_t s_r;
   wst_t s_nxt;

   assign ctrl = s_r.c;
   assign ptr1 = s_r.p1;
   assign ptr2 = s_r.p2;

   always_comb begin
      s_nxt = s_r;
      if (we) begin
         if (idx == 2'h1) begin
            s_nxt.c = wdata;
         end else if (idx == 2'h2) begin
            s_nxt.p1 = wdata;
         end else if (idx == 2'h3) begin
            s_nxt.p2 = wdata;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule
`default_nettype wire

// *** verilog/tx_desc_decode.sv ***
// transmit descriptor fetch and control word decode
// assumes a memory read port on the same clock with one outstanding read
`timescale 1ns/1ps
`default_nettype none
`include "txdesc_defines.svh"
module tx_desc_decode (
   input  wire logic        SYS_CLK,      // 200 MHz clock
   input  wire logic        SYS_RST,      // async reset, high
   input  wire logic        START,        // fetch a descriptor pulse
   input  wire logic        RESTART_BASE, // reload from list base pulse
   input  wire logic [31:0] LIST_BASE,    // transmit list base address
   output logic             MEM_REQ,      // memory read request
   output logic      [31:0] MEM_ADDR,     // memory read address
   input  wire logic        MEM_ACK,      // read data valid
   input  wire logic [31:0] MEM_RDATA,    // read data
   output logic             BUSY,         // fetch in progress
   output logic      [31:0] CUR_DESC,     // current descriptor address
   output logic             OUT_VALID,    // decoded entry ready
   input  wire logic        OUT_READY,    // consumer takes entry
   output logic             FIRST_SEG,    // first segment flag
   output logic             LAST_SEG,     // last segment flag
   output logic             CRC_APPEND,   // append crc
   output logic             PAD_ENABLE,   // pad short frames
   output logic             END_OF_RING,  // last descriptor of ring
   output logic             CHAINED,      // second address word is next descriptor
   output logic      [10:0] BUF1_SIZE,    // buffer one bytes
   output logic      [10:0] BUF2_SIZE,    // buffer two bytes
   output logic      [31:0] BUF1_PTR,     // buffer one address
   output logic      [31:0] BUF2_PTR,     // buffer two address
   output logic      [31:0] NEXT_DESC,    // next descriptor address
   output logic      [10:0] MIN_FRAME     // pad threshold bytes
);
   localparam int DW = $bits(txdesc_pkg::decoded_t);

   typedef struct packed {
      txdesc_pkg::state_t st;
      logic [1:0]         idx;
      logic [31:0]        desc;
      logic               req;
      logic [31:0]        addr;
   } st_t;

   st_t                  s_r;
   st_t                  s_nxt;
   logic [31:0]          w_ctrl;
   logic [31:0]          w_ptr1;
   logic [31:0]          w_ptr2;
   logic                 fifo_in_ready;
   logic                 fifo_out_valid;
   txdesc_pkg::decoded_t fifo_out;
   txdesc_pkg::decoded_t dec;
   txdesc_pkg::decoded_t out_r;
   logic                 out_valid_r;
   logic                 push;
   logic                 take;

   function automatic txdesc_pkg::decoded_t decode(input logic [31:0] c,
                                                   input logic [31:0] p1,
                                                   input logic [31:0] p2,
                                                   input logic [31:0] here);
      txdesc_pkg::decoded_t d;
      logic                 fs;
      logic                 ring;
      logic                 chn;
      fs   = c[`FIRST_SEG_BIT];
      ring = c[`END_RING_BIT];
      chn  = c[`CHAINED_BIT] && !ring;
      d.first_seg   = fs;
      d.last_seg    = c[`LAST_SEG_BIT];
      // pad forces crc; options count only on first segments
      d.pad_enable  = fs && !c[`PAD_DIS_BIT];
      d.crc_append  = !(fs && c[`CRC_DIS_BIT]) || d.pad_enable;
      d.end_of_ring = ring;
      d.chained     = chn;
      d.buf1_size   = c[`BUF1_SIZE_HI:`BUF1_SIZE_LO];
      d.buf2_size   = chn ? 11'h000 : c[`BUF2_SIZE_HI:`BUF2_SIZE_LO];
      d.buf1_ptr    = p1;
      d.buf2_ptr    = chn ? 32'h0000_0000 : p2;
      if (ring) begin
         d.next_desc = 32'h0000_0000;
      end else if (chn) begin
         d.next_desc = p2;
      end else begin
         d.next_desc = here + (`WORD_STRIDE << 2);
      end
      return d;
   endfunction

   // bit 22 and the status word are read but never acted on
   desc_word_reg u_words (
      .clk   (SYS_CLK),
      .rst   (SYS_RST),
      .we    (MEM_ACK && s_r.st == txdesc_pkg::ST_WAIT),
      .idx   (s_r.idx),
      .wdata (MEM_RDATA),
      .ctrl  (w_ctrl),
      .ptr1  (w_ptr1),
      .ptr2  (w_ptr2)
   );

   assign dec  = decode(w_ctrl, w_ptr1, w_ptr2, s_r.desc);
   assign push = (s_r.st == txdesc_pkg::ST_EMIT) && fifo_in_ready;
   assign take = fifo_out_valid && (!out_valid_r || OUT_READY);

   tx_fifo #(
      .WIDTH (DW),
      .DEPTH (`FIFO_DEPTH),
      .AW    (`FIFO_AW)
   ) u_fifo (
      .clk       (SYS_CLK),
      .rst       (SYS_RST),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (dec),
      .out_valid (fifo_out_valid),
      .out_ready (take),
      .out_data  (fifo_out)
   );

   always_comb begin
      s_nxt     = s_r;
      s_nxt.req = 1'b0;
      case (s_r.st)
         txdesc_pkg::ST_IDLE: begin
            if (RESTART_BASE) begin
               s_nxt.desc = LIST_BASE;
            end else if (START) begin
               s_nxt.st   = txdesc_pkg::ST_REQ;
               s_nxt.idx  = 2'h0;
            end
         end
         txdesc_pkg::ST_REQ: begin
            s_nxt.req  = 1'b1;
            s_nxt.addr = s_r.desc + (32'(s_r.idx) << 2);
            s_nxt.st   = txdesc_pkg::ST_WAIT;
         end
         txdesc_pkg::ST_WAIT: begin
            if (MEM_ACK) begin
               if (s_r.idx == 2'h3) begin
                  s_nxt.st = txdesc_pkg::ST_EMIT;
               end else begin
                  s_nxt.idx = s_r.idx + 2'h1;
                  s_nxt.st  = txdesc_pkg::ST_REQ;
               end
            end
         end
         txdesc_pkg::ST_EMIT: begin
            if (fifo_in_ready) begin
               s_nxt.st = txdesc_pkg::ST_IDLE;
               if (dec.end_of_ring) begin
                  s_nxt.desc = LIST_BASE;
               end else begin
                  s_nxt.desc = dec.next_desc;
               end
            end
         end
         default: begin
            s_nxt.st = txdesc_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         s_r         <= '0;
         out_r       <= '0;
         out_valid_r <= 1'b0;
      end else begin
         s_r <= s_nxt;
         if (take) begin
            out_r       <= fifo_out;
            out_valid_r <= 1'b1;
         end else if (OUT_READY) begin
            out_valid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         BUSY     <= 1'b0;
         MEM_REQ  <= 1'b0;
         MEM_ADDR <= 32'h0000_0000;
         CUR_DESC <= 32'h0000_0000;
         MIN_FRAME <= `MIN_FRAME_BYTES;
      end else begin
         BUSY     <= (s_nxt.st != txdesc_pkg::ST_IDLE);
         MEM_REQ  <= s_nxt.req;
         MEM_ADDR <= s_nxt.addr;
         CUR_DESC <= s_nxt.desc;
         MIN_FRAME <= `MIN_FRAME_BYTES;
      end
   end

   assign OUT_VALID   = out_valid_r;
   assign FIRST_SEG   = out_r.first_seg;
   assign LAST_SEG    = out_r.last_seg;
   assign CRC_APPEND  = out_r.crc_append;
   assign PAD_ENABLE  = out_r.pad_enable;
   assign END_OF_RING = out_r.end_of_ring;
   assign CHAINED     = out_r.chained;
   assign BUF1_SIZE   = out_r.buf1_size;
   assign BUF2_SIZE   = out_r.buf2_size;
   assign BUF1_PTR    = out_r.buf1_ptr;
   assign BUF2_PTR    = out_r.buf2_ptr;
   assign NEXT_DESC   = out_r.next_desc;
endmodule
`default_nettype wire

// *** test/tx_desc_decode_sva.sv ***
// port assertions for the descriptor decoder
// assumes a bind onto tx_desc_decode
`timescale 1ns/1ps
`default_nettype none
module tx_desc_decode_sva (
   input wire logic        SYS_CLK,      // clock
   input wire logic        SYS_RST,      // reset
   input wire logic        START,        // fetch
   input wire logic        RESTART_BASE, // reload
   input wire logic        BUSY,         // busy
   input wire logic        MEM_REQ,      // request
   input wire logic        MEM_ACK,      // answer
   input wire logic [31:0] MEM_ADDR,     // address
   input wire logic [31:0] CUR_DESC,     // descriptor
   input wire logic        OUT_VALID,    // shown
   input wire logic        OUT_READY,    // taken
   input wire logic        FIRST_SEG,    // first
   input wire logic        CRC_APPEND,   // crc
   input wire logic        PAD_ENABLE,   // pad
   input wire logic        END_OF_RING,  // ring end
   input wire logic        CHAINED,      // chained
   input wire logic [10:0] BUF2_SIZE,    // size two
   input wire logic [31:0] BUF2_PTR,     // pointer two
   input wire logic [31:0] NEXT_DESC,    // next
   input wire logic [10:0] MIN_FRAME     // threshold
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (SYS_RST);
   chk_req_single: assert property (MEM_REQ |=> !MEM_REQ)
      else $error("request longer than one cycle");
   chk_fetch_start: assert property (START && !BUSY && !RESTART_BASE |=>
      BUSY ##1 (MEM_REQ && MEM_ADDR == $past(CUR_DESC, 2)))
      else $error("first read not at descriptor");
   chk_word_step: assert property (MEM_ACK && MEM_ADDR[3:2] != 2'h3 |=>
      ##1 (MEM_REQ && MEM_ADDR == $past(MEM_ADDR, 2) + 32'h4))
      else $error("next word not at plus four");
   chk_out_stands: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID &&
      $stable({FIRST_SEG, CRC_APPEND, PAD_ENABLE, END_OF_RING, CHAINED, BUF2_SIZE,
      BUF2_PTR, NEXT_DESC}))
      else $error("entry changed before taken");
   chk_crc_nonfirst: assert property (OUT_VALID && !FIRST_SEG |-> CRC_APPEND)
      else $error("crc dropped on later segment");
   chk_pad_first: assert property (OUT_VALID && PAD_ENABLE |-> FIRST_SEG && CRC_APPEND)
      else $error("pad without first or crc");
   chk_ring_chain: assert property (OUT_VALID && END_OF_RING |-> !CHAINED && NEXT_DESC == 0)
      else $error("ring end decoded wrong");
   chk_chain_buf2: assert property (OUT_VALID && CHAINED |-> BUF2_SIZE == 0 && BUF2_PTR == 0)
      else $error("buffer two kept when chained");
   chk_min_frame: assert property (MIN_FRAME == 11'h040)
      else $error("pad threshold wrong");
   cover property (OUT_VALID && OUT_READY && CHAINED);
   cover property (OUT_VALID && OUT_READY && END_OF_RING);
   cover property (OUT_VALID && !OUT_READY && BUSY);
endmodule
`default_nettype wire

// *** test/host_mem_model.sv ***
// host memory answering descriptor reads
// assumes one read outstanding, words filled by the bench
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
   input  wire logic        clk,   // clock
   input  wire logic        rst,   // reset
   input  wire logic        req,   // read request
   input  wire logic [31:0] addr,  // read address
   output logic             ack,   // answer strobe
   output logic      [31:0] rdata  // answer word
);
   logic [31:0] words [0:63];
   logic        pend;
   int          wait_n;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack <= 1'b0;
         pend <= 1'b0;
         wait_n <= 0;
         rdata <= 32'h0;
      end else begin
         ack <= 1'b0;
         rdata <= ~rdata; // no stale word outside answers
         if (req) begin
            pend <= 1'b1;
            wait_n <= $urandom_range(3);
         end else if (pend && wait_n != 0)
            wait_n <= wait_n - 1;
         else if (pend) begin
            pend <= 1'b0;
            ack <= 1'b1;
            rdata <= words[addr[7:2]];
         end
      end
   end
endmodule
`default_nettype wire

// *** test/tb_tx_desc_decode.sv ***
// bench for the descriptor decoder
// assumes host_mem_model on the read port
`timescale 1ns/1ps
`default_nettype none
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module tb_tx_desc_decode;
   localparam logic [31:0] BASE = 32'h0000_0040;
   logic clk = 1'b0, rst = 1'b1, start = 1'b0, restart = 1'b0, rdy = 1'b0;
   wire logic mreq, mack, busy, vld;
   wire logic [31:0] maddr, mdata, cur;
   wire logic [10:0] minf;
   wire txdesc_pkg::decoded_t got;
   txdesc_pkg::decoded_t q[$];
   logic [31:0] ecur;
   int n_mismatch = 0, n_compared = 0, cyc = 0, n;
   logic [31:0] corner [6] = '{32'h64bf_ffff, 32'h2400_0040, 32'h0480_0010,
                               32'h0300_2800, 32'h0100_0020, 32'h4040_0100};
   tx_desc_decode dut (.SYS_CLK(clk), .SYS_RST(rst), .START(start),
      .RESTART_BASE(restart), .LIST_BASE(BASE), .MEM_REQ(mreq), .MEM_ADDR(maddr),
      .MEM_ACK(mack), .MEM_RDATA(mdata), .BUSY(busy), .CUR_DESC(cur),
      .OUT_VALID(vld), .OUT_READY(rdy), .FIRST_SEG(got.first_seg),
      .LAST_SEG(got.last_seg), .CRC_APPEND(got.crc_append),
      .PAD_ENABLE(got.pad_enable), .END_OF_RING(got.end_of_ring),
      .CHAINED(got.chained), .BUF1_SIZE(got.buf1_size), .BUF2_SIZE(got.buf2_size),
      .BUF1_PTR(got.buf1_ptr), .BUF2_PTR(got.buf2_ptr), .NEXT_DESC(got.next_desc),
      .MIN_FRAME(minf));
   host_mem_model host (.clk(clk), .rst(rst), .req(mreq), .addr(maddr),
      .ack(mack), .rdata(mdata));
   initial begin
      forever #2.5 clk = ~clk;
   end
   function automatic txdesc_pkg::decoded_t exp_dec(input logic [31:0] c, p1, p2, here);
      txdesc_pkg::decoded_t d;
      d.first_seg = c[29];
      d.last_seg = c[30];
      d.pad_enable = c[29] & ~c[23];
      d.crc_append = ~(c[29] & c[26]) | d.pad_enable;
      d.end_of_ring = c[25];
      d.chained = c[24] & ~c[25];
      d.buf1_size = c[10:0];
      d.buf2_size = d.chained ? 11'h0 : c[21:11];
      d.buf1_ptr = p1;
      d.buf2_ptr = d.chained ? 32'h0 : p2;
      d.next_desc = d.chained ? p2 : c[25] ? 32'h0 : here + 32'h10;
      return d;
   endfunction
   function automatic logic [31:0] rnd_ctrl();
      logic [31:0] c;
      c = $urandom & ~32'h0040_0000;
      if (c[24] & ~c[25])
         c[21:11] = 11'h0;
      return c;
   endfunction
   task automatic fetch(input logic [31:0] c);
      logic [31:0] p1, p2;
      p1 = $urandom;
      p2 = (c[24] & ~c[25]) ? {24'h0, 4'($urandom), 4'h0} : $urandom;
      host.words[ecur[7:2]] = $urandom;
      host.words[6'(ecur[7:2] + 1)] = c;
      host.words[6'(ecur[7:2] + 2)] = p1;
      host.words[6'(ecur[7:2] + 3)] = p2;
      q.push_back(exp_dec(c, p1, p2, ecur));
      ecur = (c[24] & ~c[25]) ? p2 : c[25] ? BASE : ecur + 32'h10;
      @(negedge clk) start = 1'b1;
      @(negedge clk) start = 1'b0;
      repeat (60) @(negedge clk) if (!busy) break;
      if (!busy) `CMP(cur, ecur)
   endtask
   task automatic drain();
      txdesc_pkg::decoded_t e;
      repeat (100) @(negedge clk) if (vld) break;
      repeat ($urandom_range(2)) @(negedge clk);
      e = q.pop_front();
      `CMP(got, e)
      rdy = 1'b1;
      @(negedge clk) rdy = 1'b0;
   endtask
   task automatic finish_test();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(32'hcd67));
      repeat (16) @(negedge clk);
      rst = 1'b0;
      start = 1'b1;
      restart = 1'b1;
      @(negedge clk) start = 1'b0;
      restart = 1'b0;
      repeat (2) @(negedge clk);
      `CMP({busy, cur}, {1'b0, BASE})
      ecur = BASE;
      $display("test restart done");
      foreach (corner[i]) begin
         fetch(corner[i]);
         drain();
      end
      $display("test corners done");
      repeat (12) begin
         fetch(rnd_ctrl());
         drain();
      end
      $display("test random done");
      for (n = 0; n < 12 && !busy; n++)
         fetch(rnd_ctrl());
      `CMP({busy, n > 8}, 2'b11)
      while (q.size() > 0)
         drain();
      $display("test fill done");
      finish_test();
   end
endmodule
bind tx_desc_decode tx_desc_decode_sva chk (.SYS_CLK, .SYS_RST, .START, .RESTART_BASE,
   .BUSY, .MEM_REQ, .MEM_ACK, .MEM_ADDR, .CUR_DESC, .OUT_VALID, .OUT_READY, .FIRST_SEG,
   .CRC_APPEND, .PAD_ENABLE, .END_OF_RING, .CHAINED, .BUF2_SIZE, .BUF2_PTR, .NEXT_DESC,
   .MIN_FRAME);
`default_nettype wire
